// *** inc/wdg_pkg.sv ***
// constants, types and decode helpers shared by the watchdog files
package wdg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register port
    localparam int              ADDR_W     = 8;    // register address width
    localparam int              DATA_W     = 8;    // register data width
    localparam logic [7:0]      OFF_CTRL   = 8'h00; // control register
    localparam logic [7:0]      OFF_STATUS = 8'h01; // status register
    localparam logic [7:0]      RD_ZERO    = 8'h00; // unmapped read value

    ////////////////////////////////////////////////////////////////////////
    // control and status field layout
    localparam int              FLD_W      = 4;    // width of a code field
    localparam int              PER_LSB    = 0;    // period code position
    localparam int              WIN_LSB    = 4;    // window code position
    localparam int              LOCK_BIT   = 7;    // lock bit position
    localparam int              BUSY_BIT   = 0;    // sync busy position
    localparam logic [3:0]      CODE_OFF   = 4'h0; // field code: off
    localparam logic [3:0]      CODE_ONE   = 4'h1; // shortest interval
    localparam logic [3:0]      CODE_MAX   = 4'hB; // longest interval

    ////////////////////////////////////////////////////////////////////////
    // timing of the watchdog oscillator
    localparam int              OSC_FREQ_HZ     = 1000; // oscillator rate
    localparam int              BASE_TIMEOUT_MS = 8;    // shortest time-out
    localparam int              BASE_CYCLES     =
        (BASE_TIMEOUT_MS * OSC_FREQ_HZ + 999) / 1000;
    localparam int              CNT_W      = 14;   // holds 8K cycles
    localparam logic [13:0]     CNT_ZERO   = 14'h0000;
    localparam logic [13:0]     CNT_ONE    = 14'h0001;

    ////////////////////////////////////////////////////////////////////////
    // counter phases on the oscillator side
    typedef enum logic [1:0] {
        S_FREE,     // normal interval, or window mode waiting first clear
        S_CLOSED,   // closed slot: a clear here is too early
        S_OPEN      // open slot: a clear is expected here
    } wdg_state_t;

    // interval length in oscillator cycles; reserved codes map to the max
    function automatic logic [CNT_W-1:0] code_len(
        input logic [FLD_W-1:0] code
    );
        logic [FLD_W-1:0] sel;
        sel      = (code > CODE_MAX) ? CODE_MAX : code;
        code_len = CNT_W'(BASE_CYCLES) << (sel - CODE_ONE);
    endfunction

endpackage

// *** rtl/wdg_sync.sv ***
// multi-bit two flip-flop level synchroniser
`timescale 1ns/100ps
module wdg_sync #(
    parameter int WIDTH = 1             // number of independent levels
) (
    // clock and reset of the receiving domain
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // levels in and out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    ////////////////////////////////////////////////////////////////////////
    // one two-stage chain per bit; stage one feeds only stage two
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_r;               // first stage, metastable
            logic hold_r;               // second stage, safe to use
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    meta_r <= 1'b0;
                    hold_r <= 1'b0;
                end else begin
                    meta_r <= d_i[gi];
                    hold_r <= meta_r;
                end
            end
            assign q_o[gi] = hold_r;
        end
    endgenerate

endmodule

// *** rtl/wdg_unit.sv ***
// windowed watchdog: register side, crossings and oscillator-side counter
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
// Functional notes
// - missed clear while enabled requests system reset
// - clear instruction restarts the counter
// - every accepted clear outside the closed slot starts full interval
// - counter runs on 1 kHz oscillator clock
// - eleven intervals chosen by period code
// - window clear too early or late resets
// - keeps counting and resetting without main clock
// - control writes cross into oscillator domain
// - debug without halt leaves counting unchanged
// - processor halt stops watchdog operation
// - processor halt zeroes the counter
// - after halt, window mode runs normal interval
// - non-zero period enables, zero disables
// - non-zero window code selects window mode
// - writes need the change protection sequence
// - control reset value comes from fuse
// - fuse-enabled watchdog sets lock at boot
// - codes 1..11 give 8..8K cycles, doubling
// - open slot follows closed slot
// - lock set-only, blocks control, debug clears
// - clear syncs 2-3 cycles, extras ignored
module wdg_unit
    import wdg_pkg::*;
(
    // system clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              resetn_i,
    // watchdog oscillator clock
    input  wire logic              wdog_osc_clock_i,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    // processor side controls
    input  wire logic              change_protection_seq_i,
    input  wire logic              wdog_clear_instruction_i,
    input  wire logic [DATA_W-1:0] wdog_config_fuse_i,
    input  wire logic              dbg_mode_i,
    input  wire logic              dbg_halt_i,
    // results
    output logic                   wdog_rst_req_o,
    output logic                   sync_pending_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // system domain state
    logic [DATA_W-1:0] ctrl_r;          // control register, visible copy
    logic              lock_r;          // configuration lock
    logic              boot_r;          // fuse has been loaded
    logic              ctl_req_r;       // control update toggle
    logic              clr_req_r;       // clear instruction toggle
    logic [DATA_W-1:0] rdata_r;         // read data, one cycle late
    logic [1:0]        ack_s;           // acks seen in system domain

    // system domain decode
    wire               wr_ok;           // protected write allowed
    wire               hit_ctrl;        // address is control
    wire               hit_stat;        // address is status
    wire               ctl_busy;        // control update in flight
    wire               clr_busy;        // clear in flight
    wire               ctrl_wr;         // control write accepted
    wire               lock_set;        // lock being set
    wire               lock_clr;        // lock being cleared
    wire               clr_take;        // clear instruction accepted
    wire               fuse_en;         // fuse enables the watchdog
    wire [DATA_W-1:0]  stat_val;        // status read value
    wire [DATA_W-1:0]  rd_mux;          // read data selection

    assign wr_ok    = reg_wr_i & change_protection_seq_i;
    assign hit_ctrl = (reg_addr_i == OFF_CTRL);
    assign hit_stat = (reg_addr_i == OFF_STATUS);
    assign ctl_busy = ctl_req_r ^ ack_s[1];
    assign clr_busy = clr_req_r ^ ack_s[0];
    // lock and pending sync both refuse a control write
    assign ctrl_wr  = wr_ok & hit_ctrl & ~lock_r & ~ctl_busy & boot_r;
    assign lock_set = wr_ok & hit_stat & reg_wdata_i[LOCK_BIT];
    assign lock_clr = wr_ok & hit_stat & ~reg_wdata_i[LOCK_BIT]
                      & dbg_mode_i;
    // a clear during an earlier clear's crossing is dropped
    assign clr_take = wdog_clear_instruction_i & ~clr_busy;
    assign fuse_en  = (wdog_config_fuse_i[PER_LSB +: FLD_W] != CODE_OFF);
    assign stat_val = {lock_r, {(DATA_W-2){1'b0}}, ctl_busy};
    assign rd_mux   = hit_ctrl ? ctrl_r :
                      hit_stat ? stat_val : RD_ZERO;

    ////////////////////////////////////////////////////////////////////////
    // boot: fuse capture on the first edge after reset release
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            boot_r <= 1'b0;
        end else begin
            boot_r <= 1'b1;
        end
    end

    // control register: fuse at boot, else protected writes
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ctrl_r <= RD_ZERO;
        end else if (!boot_r) begin
            ctrl_r <= wdog_config_fuse_i;
        end else if (ctrl_wr) begin
            ctrl_r <= reg_wdata_i;
        end
    end

    // lock: automatic at boot, set-only by software, debug clears
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            lock_r <= 1'b0;
        end else if (!boot_r) begin
            lock_r <= fuse_en;
        end else if (lock_set) begin
            lock_r <= 1'b1;
        end else if (lock_clr) begin
            lock_r <= 1'b0;
        end
    end

    // request toggles: control update and clear instruction
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ctl_req_r <= 1'b0;
            clr_req_r <= 1'b0;
        end else begin
            // boot load also pushes the fuse value across
            if (!boot_r || ctrl_wr) begin
                ctl_req_r <= ~ctl_req_r;
            end
            if (clr_take) begin
                clr_req_r <= ~clr_req_r;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rdata_r <= RD_ZERO;
        end else begin
            rdata_r <= reg_rd_i ? rd_mux : RD_ZERO;
        end
    end

    assign reg_rdata_o         = rdata_r;
    assign sync_pending_flag_o = ctl_busy;

    ////////////////////////////////////////////////////////////////////////
    // oscillator domain reset and synchronisers
    logic              osc_rst_n;       // reset seen by oscillator domain
    logic [2:0]        osc_s;           // {halt, ctl_req, clr_req}
    logic              ctl_seen_r;      // last control toggle taken
    logic              clr_seen_r;      // last clear toggle taken

    wdg_sync #(.WIDTH(1)) u_rst_sync (
        .clk_i   (wdog_osc_clock_i),
        .rst_n_i (1'b1),
        .d_i     (resetn_i),
        .q_o     (osc_rst_n)
    );

    wdg_sync #(.WIDTH(3)) u_osc_sync (
        .clk_i   (wdog_osc_clock_i),
        .rst_n_i (osc_rst_n),
        .d_i     ({dbg_halt_i, ctl_req_r, clr_req_r}),
        .q_o     (osc_s)
    );

    // acknowledges travel back to the system domain
    wdg_sync #(.WIDTH(2)) u_ack_sync (
        .clk_i   (ref_clk_i),
        .rst_n_i (resetn_i),
        .d_i     ({ctl_seen_r, clr_seen_r}),
        .q_o     (ack_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // oscillator domain state
    logic [FLD_W-1:0]  pcode_r;         // applied period code
    logic [FLD_W-1:0]  wcode_r;         // applied window code
    logic [CNT_W-1:0]  cnt_r;           // watchdog counter
    logic [CNT_W-1:0]  cnt_nxt;
    wdg_state_t        state_r;         // counter phase
    wdg_state_t        state_nxt;
    logic              rst_r;           // reset request, sticky
    logic              fire;            // interval violated

    // oscillator domain decode
    wire               halt_s;          // processor halted by debugger
    wire               ctl_evt;         // new control value arrived
    wire               clr_evt;         // clear instruction arrived
    wire               en;              // watchdog enabled
    wire               win;             // window mode selected
    wire [CNT_W-1:0]   p_len;           // open or normal length
    wire [CNT_W-1:0]   w_len;           // closed slot length
    wire               p_hit;           // last cycle of period
    wire               w_hit;           // last cycle of closed slot
    wire [CNT_W-1:0]   cnt_inc;         // counter plus one

    assign halt_s  = osc_s[2];
    assign ctl_evt = osc_s[1] ^ ctl_seen_r;
    assign clr_evt = osc_s[0] ^ clr_seen_r;
    assign en      = (pcode_r != CODE_OFF);
    assign win     = (wcode_r != CODE_OFF);
    assign p_len   = code_len(pcode_r);
    assign w_len   = code_len(wcode_r);
    assign p_hit   = (cnt_r == p_len - CNT_ONE);
    assign w_hit   = (cnt_r == w_len - CNT_ONE);
    assign cnt_inc = CNT_W'(cnt_r + CNT_ONE);

    // next counter phase; debug mode alone has no influence here
    always_comb begin
        cnt_nxt   = cnt_inc;
        state_nxt = state_r;
        fire      = 1'b0;
        if (ctl_evt || halt_s || !en || rst_r) begin
            // new setting, halt or disable: restart without a closed slot
            cnt_nxt   = CNT_ZERO;
            state_nxt = S_FREE;
        end else begin
            case (state_r)
                S_FREE: begin
                    if (clr_evt) begin
                        cnt_nxt   = CNT_ZERO;
                        state_nxt = win ? S_CLOSED : S_FREE;
                    end else if (p_hit) begin
                        fire      = 1'b1;
                    end
                end
                S_CLOSED: begin
                    if (clr_evt) begin
                        fire      = 1'b1;
                    end else if (w_hit) begin
                        cnt_nxt   = CNT_ZERO;
                        state_nxt = S_OPEN;
                    end
                end
                S_OPEN: begin
                    if (clr_evt) begin
                        cnt_nxt   = CNT_ZERO;
                        state_nxt = S_CLOSED;
                    end else if (p_hit) begin
                        fire      = 1'b1;
                    end
                end
                default: begin
                    cnt_nxt   = CNT_ZERO;
                    state_nxt = S_FREE;
                end
            endcase
        end
    end

    // counter and phase run on the oscillator only
    always_ff @(posedge wdog_osc_clock_i) begin
        if (!osc_rst_n) begin
            cnt_r   <= CNT_ZERO;
            state_r <= S_FREE;
        end else begin
            cnt_r   <= cnt_nxt;
            state_r <= state_nxt;
        end
    end

    // reset request holds until the system reset arrives
    always_ff @(posedge wdog_osc_clock_i) begin
        if (!osc_rst_n) begin
            rst_r <= 1'b0;
        end else begin
            rst_r <= rst_r | fire;
        end
    end

    // take new settings and toggles; control word is stable while busy
    always_ff @(posedge wdog_osc_clock_i) begin
        if (!osc_rst_n) begin
            pcode_r    <= CODE_OFF;
            wcode_r    <= CODE_OFF;
            ctl_seen_r <= 1'b0;
            clr_seen_r <= 1'b0;
        end else begin
            if (ctl_evt) begin
                pcode_r <= ctrl_r[PER_LSB +: FLD_W];
                wcode_r <= ctrl_r[WIN_LSB +: FLD_W];
            end
            ctl_seen_r <= osc_s[1];
            clr_seen_r <= osc_s[0];
        end
    end

    assign wdog_rst_req_o = rst_r;

    ////////////////////////////////////////////////////////////////////////
    // checks, oscillator domain
    wire run_ok = en & ~halt_s & ~ctl_evt & ~rst_r;  // counter free to act

    a_normal_timeout: assert property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        run_ok && state_r == S_FREE && p_hit && !clr_evt
        |=> rst_r ##1 rst_r)
        else $error("missed clear did not raise reset");
    a_early_clear: assert property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        run_ok && state_r == S_CLOSED && clr_evt |=> wdog_rst_req_o)
        else $error("early clear did not raise reset");
    a_clear_restart: assert property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        run_ok && state_r != S_CLOSED && clr_evt
        |=> cnt_r == CNT_ZERO && !rst_r)
        else $error("clear did not restart interval");
    a_halt_zero: assert property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        halt_s |=> cnt_r == CNT_ZERO)
        else $error("halt left counter non-zero");
    a_halt_noreset: assert property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        halt_s && !rst_r |=> !rst_r)
        else $error("reset raised during halt");
    a_resume_free: assert property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        $fell(halt_s) |-> state_r == S_FREE)
        else $error("resume did not start normal interval");
    a_open_count: assert property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        run_ok && state_r == S_OPEN && !clr_evt && !p_hit
        |=> cnt_r == $past(cnt_r) + CNT_ONE)
        else $error("counter did not advance");
    a_off_idle: assert property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        !en && !rst_r |=> !rst_r && cnt_r == CNT_ZERO)
        else $error("disabled watchdog is counting");

    // checks, system domain
    a_guard_write: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        boot_r && reg_wr_i && !change_protection_seq_i
        |=> ctrl_r == $past(ctrl_r) && lock_r == $past(lock_r))
        else $error("unprotected write changed settings");
    a_lock_block: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        boot_r && lock_r && reg_wr_i && hit_ctrl |=> $stable(ctrl_r))
        else $error("locked control register changed");
    a_boot_lock: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        $rose(boot_r) |-> lock_r ==
            ($past(wdog_config_fuse_i[PER_LSB +: FLD_W]) != CODE_OFF))
        else $error("boot lock does not follow fuse");
    a_clear_busy: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        clr_take |=> clr_busy ##1 clr_busy)
        else $error("clear crossing not marked busy");

    c_window_cycle: cover property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        state_r == S_OPEN && clr_evt && run_ok);
    c_open_timeout: cover property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        state_r == S_OPEN && fire);
    c_halt_resume: cover property (@(posedge wdog_osc_clock_i)
        disable iff (!osc_rst_n)
        $fell(halt_s) && win);
    c_ctrl_write: cover property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        ctrl_wr);

endmodule

// *** sim/wdg_core_model.sv ***
// processor core model: register master, protection key and clears
`timescale 1ns/100ps
module wdg_core_model
    import wdg_pkg::*;
(
    // system clock
    input  wire logic              ref_clk_i,
    // register port toward the watchdog
    output logic      [ADDR_W-1:0] reg_addr_o,
    output logic      [DATA_W-1:0] reg_wdata_o,
    output logic                   reg_wr_o,
    output logic                   reg_rd_o,
    input  wire logic [DATA_W-1:0] reg_rdata_i,
    // key window and clear instruction
    output logic                   change_protection_seq_o,
    output logic                   wdog_clear_instruction_o
);
    // idle bus at time zero
    initial begin
        reg_addr_o               = 8'hff;
        reg_wdata_o              = 8'h5a;
        reg_wr_o                 = 1'b0;
        reg_rd_o                 = 1'b0;
        change_protection_seq_o  = 1'b0;
        wdog_clear_instruction_o = 1'b0;
    end
    // one write; released address and data carry the inverse of the last value, strobe and key go low
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic key);
        @(posedge ref_clk_i);
        reg_wr_o                <= 1'b1;
        reg_addr_o              <= a;
        reg_wdata_o             <= d;
        change_protection_seq_o <= key;
        @(posedge ref_clk_i);
        reg_wr_o                <= 1'b0;
        reg_addr_o              <= ~a;
        reg_wdata_o             <= ~d;
        change_protection_seq_o <= 1'b0;
    endtask
    // one read; data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_rd_o   <= 1'b1;
        reg_addr_o <= a;
        @(posedge ref_clk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        d = reg_rdata_i;
    endtask
    // one clear instruction pulse
    task automatic clr();
        @(posedge ref_clk_i);
        wdog_clear_instruction_o <= 1'b1;
        @(posedge ref_clk_i);
        wdog_clear_instruction_o <= 1'b0;
    endtask
endmodule

// *** sim/wdg_unit_bench.sv ***
// self-checking bench for the windowed watchdog unit
`timescale 1ns/100ps
module wdg_unit_bench
    import wdg_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    // design signals and counters
    logic              ref_clk_i, wdog_osc_clock_i, resetn_i;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, wdog_config_fuse_i;
    logic              reg_wr_i, reg_rd_i, change_protection_seq_i;
    logic              wdog_clear_instruction_i, dbg_mode_i, dbg_halt_i;
    logic              wdog_rst_req_o, sync_pending_flag_o;
    int                bad_count, checks_done, n;
    // rows: control value and time-out in oscillator cycles
    typedef struct { logic [7:0] ctrl; int len; } wdg_row_t;
    wdg_row_t rows [4] = '{'{8'h01, 8}, '{8'h02, 16}, '{8'h03, 32},
                          '{8'h12, 16}};
    ////////////////////////////////////////////////////////////////////////
    // design and core model
    wdg_unit wdg_unit_i (.ref_clk_i, .resetn_i, .wdog_osc_clock_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .change_protection_seq_i, .wdog_clear_instruction_i,
        .wdog_config_fuse_i, .dbg_mode_i, .dbg_halt_i, .wdog_rst_req_o,
        .sync_pending_flag_o);
    wdg_core_model wdg_core_model_i (.ref_clk_i, .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_rdata_i(reg_rdata_o),
        .change_protection_seq_o(change_protection_seq_i),
        .wdog_clear_instruction_o(wdog_clear_instruction_i));
    ////////////////////////////////////////////////////////////////////////
    // clocks; oscillator sped up, phase unrelated to the system clock
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        wdog_osc_clock_i = 1'b0;
        #3;
        forever #123 wdog_osc_clock_i = ~wdog_osc_clock_i;
    end
    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk_rng(string nm, int lo, int hi, int s);
        checks_done++;
        if (s < lo || s > hi) begin
            bad_count++;
            $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, s);
        end
    endtask
    task automatic rchk(string nm, logic [7:0] a, logic [7:0] e);
        logic [7:0] v;
        wdg_core_model_i.rd(a, v);
        chk(nm, e, v);
    endtask
    // wait, bounded, until the control crossing has finished; the flag
    // rises with the toggle itself, up to one edge after the call, so let two edges pass first
    task automatic wait_sync();
        repeat (2) @(posedge ref_clk_i);
        for (int k = 0; k < 4000 && sync_pending_flag_o !== 1'b0; k++)
            @(posedge ref_clk_i);
        chk("sync done", 8'h00, {7'b0, sync_pending_flag_o});
    endtask
    // reset long enough for both domains, then let boot settle
    task automatic boot(input logic [7:0] f);
        @(posedge ref_clk_i);
        resetn_i           <= 1'b0;
        wdog_config_fuse_i <= f;
        repeat (10) @(posedge ref_clk_i);
        repeat (4) @(posedge wdog_osc_clock_i);
        @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        wait_sync();
    endtask
    // oscillator edges until the reset request shows, bounded
    task automatic measure(output int c);
        c = 0;
        while (wdog_rst_req_o !== 1'b1 && c < 200) begin
            @(posedge wdog_osc_clock_i);
            #1;
            c++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #700_000;
        bad_count++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        resetn_i           = 1'b0;
        wdog_config_fuse_i = 8'h00;
        dbg_mode_i         = 1'b0;
        dbg_halt_i         = 1'b0;
        // plain time-outs per code, each from a fresh boot
        foreach (rows[i]) begin
            boot(8'h00);
            wdg_core_model_i.wr(OFF_CTRL, rows[i].ctrl, 1'b1);
            wait_sync();
            measure(n);
            chk_rng("timeout", rows[i].len - 2, rows[i].len + 3, n);
        end
        // fuse boot, lock and protection
        boot(8'h03);
        rchk("ctrl boot", OFF_CTRL, 8'h03);
        rchk("status boot", OFF_STATUS, 8'h80);
        wdg_core_model_i.wr(OFF_CTRL, 8'h01, 1'b1);
        rchk("ctrl locked", OFF_CTRL, 8'h03);
        wdg_core_model_i.wr(OFF_STATUS, 8'h00, 1'b1);
        rchk("lock kept", OFF_STATUS, 8'h80);
        dbg_mode_i <= 1'b1;
        wdg_core_model_i.wr(OFF_STATUS, 8'h00, 1'b1);
        dbg_mode_i <= 1'b0;
        rchk("lock cleared", OFF_STATUS, 8'h00);
        wdg_core_model_i.wr(OFF_CTRL, 8'h00, 1'b0);
        rchk("ctrl no key", OFF_CTRL, 8'h03);
        rchk("unmapped", 8'h05, RD_ZERO);
        wdg_core_model_i.wr(OFF_CTRL, 8'h00, 1'b1);
        wait_sync();
        repeat (64) @(posedge wdog_osc_clock_i);
        chk("disabled", 8'h00, {7'b0, wdog_rst_req_o});
        // clears keep a running watchdog alive
        wdg_core_model_i.wr(OFF_CTRL, 8'h02, 1'b1);
        wait_sync();
        dbg_mode_i <= 1'b1; // run-time debug without halt
        repeat (5) begin
            repeat (10) @(posedge wdog_osc_clock_i);
            wdg_core_model_i.clr();
        end
        chk("cleared", 8'h00, {7'b0, wdog_rst_req_o});
        measure(n);
        chk_rng("after clear", 16, 20, n);
        dbg_mode_i <= 1'b0;
        // window: clear in the open slot, then a full closed plus open
        boot(8'h00);
        wdg_core_model_i.wr(OFF_CTRL, 8'h22, 1'b1);
        wait_sync();
        wdg_core_model_i.clr();
        repeat (20) @(posedge wdog_osc_clock_i);
        wdg_core_model_i.clr();
        measure(n);
        chk_rng("window cycle", 32, 38, n);
        // window: clear in the closed slot
        boot(8'h00);
        wdg_core_model_i.wr(OFF_CTRL, 8'h22, 1'b1);
        wait_sync();
        wdg_core_model_i.clr();
        repeat (5) @(posedge wdog_osc_clock_i);
        wdg_core_model_i.clr();
        measure(n);
        chk_rng("early clear", 0, 6, n);
        // debug halt stops and zeroes the count
        boot(8'h00);
        wdg_core_model_i.wr(OFF_CTRL, 8'h22, 1'b1);
        wait_sync();
        repeat (8) @(posedge wdog_osc_clock_i);
        dbg_halt_i <= 1'b1;
        repeat (48) @(posedge wdog_osc_clock_i);
        chk("halted", 8'h00, {7'b0, wdog_rst_req_o});
        dbg_halt_i <= 1'b0;
        measure(n);
        chk_rng("after halt", 16, 21, n);
        test_done();
    end
endmodule
